// [hdl/block_transfer_command_pager.sv]
// How it works
// - In command control mode a command starts only on a 0 to 1 change of its enable bit between write transfers.
// - Each enabled command gets up to three attempts before it counts as failed.
// - A command sent successfully sets its done bit in the returned status.
// - A command that fails sets its error bit in the returned status.
// - Word 0 of every read buffer carries the read page identifier.
// - Word 1 carries the suggested next write code from parameters 21 and 22, 0-79 data, 255 configuration.
// - Words 2 to 51 carry consecutive table words from the 0 to 3999 data space.
// - Words 52 to 63 carry the done and error bit maps of the commands.
// - Slave data is kept in a 4000 word table addressed 0 to 3999.
// - Read page identifiers 0 to 79 are page numbers selecting fixed table ranges.
// - The number of read pages cycled through equals the configured read page count, with a count of 0 taken as 1 and counts above 80 held to 80.
// - Serial port data and host write data share the same table.
`default_nettype none
module block_transfer_command_pager #(
   parameter int TRIES = pager_pkg::MAX_TRIES
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   // Host write transfer
   input wire logic wr_word_valid,
   input wire logic [5:0] wr_word_index,
   input wire logic [15:0] wr_word_data,
   input wire logic wr_end,
   // Host read transfer
   input wire logic rd_req,
   output logic rd_word_valid,
   output logic [5:0] rd_word_index,
   output logic [15:0] rd_word_data,
   output logic rd_end,
   // Configuration
   input wire logic command_control_mode,
   input wire logic [6:0] read_page_count,
   input wire logic [7:0] write_start_code,
   input wire logic [7:0] write_block_count,
   // Serial port data into the table
   input wire logic port_wr_valid,
   input wire logic [11:0] port_wr_addr,
   input wire logic [15:0] port_wr_data,
   output logic port_wr_ready,
   // Serial command engine
   output logic cmd_start,
   output logic [6:0] cmd_number,
   input wire logic cmd_ok,
   input wire logic cmd_fail
);
   localparam int N = pager_pkg::NUM_CMDS;
   typedef enum logic {CMD_IDLE, CMD_WAIT} cmd_state_e;
   initial begin
      if (TRIES < 1 || TRIES > 7) $error("TRIES must lie in 1..7");
   end
   // Write side state
   logic [7:0] wr_page, next_wr_page;
   logic wr_busy, next_wr_busy, next_port_wr_ready;
   logic [N-1:0] en_stage, next_en_stage, en_prev, next_en_prev, rise;
   // Read side state
   logic rd_active, next_rd_active, s1_valid, next_s1_valid, next_rd_word_valid, next_rd_end;
   logic [5:0] rd_cnt, next_rd_cnt, s1_idx, next_s1_idx, next_rd_word_index;
   logic [6:0] rd_page, next_rd_page;
   logic [7:0] wr_off, next_wr_off;
   logic [15:0] s1_val, next_s1_val, next_rd_word_data;
   // Command state
   cmd_state_e cstate, next_cstate;
   logic [N-1:0] pending, next_pending, done, next_done, err, next_err;
   logic [2:0] tries, next_tries;
   logic next_cmd_start;
   logic [6:0] next_cmd_number;
   // Table ports
   logic mem_we;
   logic [11:0] mem_waddr, mem_raddr;
   logic [15:0] mem_wdata, mem_q;
   table_memory #(.DEPTH(4000), .WIDTH(16), .AW(12)) u_table (
      .clock(clock), .ce(ce), .we(mem_we), .waddr(mem_waddr),
      .wdata(mem_wdata), .raddr(mem_raddr), .rdata(mem_q)
   );
   // Host write words take the table first; serial writes are held off from word 1 of a write transfer through its wr_end cycle
   always_comb begin
      logic host_data;
      host_data = wr_word_valid && wr_word_index >= 6'h01 && wr_word_index <= pager_pkg::DATA_LAST - 6'h01;
      next_wr_page = wr_page;
      next_en_stage = en_stage;
      next_en_prev = en_prev;
      next_wr_busy = (wr_busy || (wr_word_valid && wr_word_index == pager_pkg::ID_WORD)) && !wr_end;
      next_port_wr_ready = !next_wr_busy;
      rise = '0;
      mem_we = 1'b0;
      mem_waddr = port_wr_addr;
      mem_wdata = port_wr_data;
      if (wr_word_valid && wr_word_index == pager_pkg::ID_WORD) begin
         next_wr_page = wr_word_data[7:0];
      end
      if (host_data && wr_page < pager_pkg::DATA_PAGES) begin
         mem_we = 1'b1;
         mem_waddr = 12'(wr_page * pager_pkg::PAGE_WORDS + 12'(wr_word_index - 6'h01));
         mem_wdata = wr_word_data;
      end else if (port_wr_valid && port_wr_ready && port_wr_addr < pager_pkg::TABLE_WORDS) begin
         mem_we = 1'b1;
      end
      if (wr_word_valid && wr_word_index >= pager_pkg::EN_FIRST && wr_word_index <= pager_pkg::EN_LAST) begin
         next_en_stage[16*(wr_word_index - pager_pkg::EN_FIRST) +: 16] = wr_word_data;
      end
      if (wr_end) begin
         rise = en_stage & ~en_prev;
         next_en_prev = en_stage;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_page <= pager_pkg::CONFIG_CODE;
         wr_busy <= 1'b0;
         port_wr_ready <= 1'b1;
         en_stage <= '0;
         en_prev <= '0;
      end else if (ce) begin
         wr_page <= next_wr_page;
         wr_busy <= next_wr_busy;
         port_wr_ready <= next_port_wr_ready;
         en_stage <= next_en_stage;
         en_prev <= next_en_prev;
      end
   end
   // Read buffer: stage one picks the word, stage two merges table data from the memory
   always_comb begin
      logic [6:0] pages;
      // Pages past the last data page would address beyond the table
      pages = (read_page_count == 7'h00) ? 7'h01 : read_page_count;
      if (read_page_count > 7'(pager_pkg::DATA_PAGES)) pages = 7'(pager_pkg::DATA_PAGES);
      next_rd_active = rd_active;
      next_rd_cnt = rd_cnt;
      next_rd_page = rd_page;
      next_wr_off = wr_off;
      next_s1_valid = 1'b0;
      next_s1_idx = rd_cnt;
      next_s1_val = 16'h0000;
      mem_raddr = 12'(rd_page * pager_pkg::PAGE_WORDS + 12'(rd_cnt - pager_pkg::DATA_FIRST));
      if (!rd_active && rd_req) begin
         next_rd_active = 1'b1;
         next_rd_cnt = 6'h00;
      end
      if (rd_active) begin
         next_s1_valid = 1'b1;
         next_rd_cnt = rd_cnt + 6'h01;
         if (rd_cnt == pager_pkg::ID_WORD) begin
            next_s1_val = {9'h000, rd_page};
         end else if (rd_cnt == pager_pkg::CODE_WORD) begin
            next_s1_val = (write_block_count == 8'h00) ? {8'h00, pager_pkg::CONFIG_CODE}
                                                      : {8'h00, 8'(write_start_code + wr_off)};
         end else if (rd_cnt >= pager_pkg::DONE_FIRST && rd_cnt < pager_pkg::ERR_FIRST) begin
            next_s1_val = done[16*(rd_cnt - pager_pkg::DONE_FIRST) +: 16];
         end else if (rd_cnt >= pager_pkg::ERR_FIRST) begin
            next_s1_val = err[16*(rd_cnt - pager_pkg::ERR_FIRST) +: 16];
         end
         if (rd_cnt == pager_pkg::LAST_WORD) begin
            next_rd_active = 1'b0;
            next_rd_page = (rd_page + 7'h01 >= pages) ? 7'h00 : rd_page + 7'h01;
            next_wr_off = (wr_off + 8'h01 >= write_block_count) ? 8'h00 : wr_off + 8'h01;
         end
      end
      next_rd_word_valid = s1_valid;
      next_rd_word_index = s1_idx;
      next_rd_end = s1_valid && s1_idx == pager_pkg::LAST_WORD;
      next_rd_word_data = (s1_idx >= pager_pkg::DATA_FIRST && s1_idx <= pager_pkg::DATA_LAST) ? mem_q : s1_val;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_active <= 1'b0;
         rd_cnt <= 6'h00;
         rd_page <= 7'h00;
         wr_off <= 8'h00;
         s1_valid <= 1'b0;
         s1_idx <= 6'h00;
         s1_val <= 16'h0000;
         rd_word_valid <= 1'b0;
         rd_word_index <= 6'h00;
         rd_word_data <= 16'h0000;
         rd_end <= 1'b0;
      end else if (ce) begin
         rd_active <= next_rd_active;
         rd_cnt <= next_rd_cnt;
         rd_page <= next_rd_page;
         wr_off <= next_wr_off;
         s1_valid <= next_s1_valid;
         s1_idx <= next_s1_idx;
         s1_val <= next_s1_val;
         rd_word_valid <= next_rd_word_valid;
         rd_word_index <= next_rd_word_index;
         rd_word_data <= next_rd_word_data;
         rd_end <= next_rd_end;
      end
   end
   // Command engine; lowest pending command runs first, one at a time
   always_comb begin
      logic [6:0] pick;
      pick = 7'h00;
      for (int i = N - 1; i >= 0; i--) begin
         if (pending[i]) pick = 7'(i);
      end
      next_cstate = cstate;
      next_tries = tries;
      next_cmd_start = 1'b0;
      next_cmd_number = cmd_number;
      next_pending = pending;
      next_done = done;
      next_err = err;
      if (command_control_mode) begin
         next_done = done & ~rise; // Rearming clears old results so the host can one-shot
         next_err = err & ~rise;
      end
      unique case (cstate)
         CMD_IDLE: begin
            if (|pending) begin
               next_cstate = CMD_WAIT;
               next_cmd_start = 1'b1;
               next_cmd_number = pick;
               next_tries = 3'h1;
            end
         end
         CMD_WAIT: begin
            if (cmd_ok) begin
               next_done[cmd_number] = 1'b1;
               next_pending[cmd_number] = 1'b0;
               next_cstate = CMD_IDLE;
            end else if (cmd_fail) begin
               if (tries >= 3'(TRIES)) begin
                  next_err[cmd_number] = 1'b1;
                  next_pending[cmd_number] = 1'b0;
                  next_cstate = CMD_IDLE;
               end else begin
                  next_cmd_start = 1'b1;
                  next_tries = tries + 3'h1;
               end
            end
         end
      endcase
      if (command_control_mode) begin
         next_pending = next_pending | rise; // A new request wins over completion
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cstate <= CMD_IDLE;
         tries <= 3'h0;
         cmd_start <= 1'b0;
         cmd_number <= 7'h00;
         pending <= '0;
         done <= '0;
         err <= '0;
      end else if (ce) begin
         cstate <= next_cstate;
         tries <= next_tries;
         cmd_start <= next_cmd_start;
         cmd_number <= next_cmd_number;
         pending <= next_pending;
         done <= next_done;
         err <= next_err;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst || !ce);
   a_no_rise_no_start: assert property ((cstate == CMD_IDLE && pending == '0 && (!wr_end || !command_control_mode))
      |=> !cmd_start) else $error("command started without a rising enable");
   a_retry_count: assert property ((cstate == CMD_WAIT && !cmd_ok && cmd_fail && tries < 3'(TRIES))
      |=> cmd_start && cmd_number == $past(cmd_number)) else $error("failed attempt not retried");
   a_fail_sets_err: assert property ((cstate == CMD_WAIT && !cmd_ok && cmd_fail && tries == 3'(TRIES))
      |=> err[cmd_number] && cstate == CMD_IDLE) else $error("error bit not set after last attempt");
   a_ok_sets_done: assert property ((cstate == CMD_WAIT && cmd_ok)
      |=> done[cmd_number] && cstate == CMD_IDLE) else $error("done bit not set on success");
   a_buffer_length: assert property ((rd_word_valid && rd_word_index != pager_pkg::LAST_WORD)
      |=> rd_word_valid && rd_word_index == $past(rd_word_index) + 6'h01) else $error("read buffer broken");
   a_end_at_last: assert property (rd_end |-> rd_word_valid && rd_word_index == pager_pkg::LAST_WORD)
      else $error("end marker off the last word");
   a_page_id_word: assert property ((rd_word_valid && rd_word_index == pager_pkg::ID_WORD)
      |-> rd_word_data < 16'h0050) else $error("page identifier out of range");
   a_page_in_count: assert property ((read_page_count != 7'h00 && $stable(read_page_count))
      |-> ##1 rd_page < read_page_count) else $error("read page beyond page count");
   a_prev_tracks: assert property (wr_end |=> en_prev == $past(en_stage))
      else $error("previous enables not kept");
   a_table_bound: assert property (mem_we |-> mem_waddr < pager_pkg::TABLE_WORDS)
      else $error("table write out of range");

   c_full_read: cover property (rd_end);
   c_cmd_done: cover property (cstate == CMD_WAIT && cmd_ok);
   c_cmd_error: cover property (cstate == CMD_WAIT && cmd_fail && tries == 3'(TRIES));
   c_retry: cover property (cmd_start ##[1:20] cmd_start);
endmodule // block_transfer_command_pager
`default_nettype wire

// [hdl/pager_pkg.sv]
`default_nettype none
package pager_pkg;
   localparam int BUF_WORDS = 64;
   localparam logic [5:0] ID_WORD = 6'h00;
   localparam logic [5:0] CODE_WORD = 6'h01;
   localparam logic [5:0] DATA_FIRST = 6'h02;
   localparam logic [5:0] DATA_LAST = 6'h33;
   localparam logic [5:0] DONE_FIRST = 6'h34;
   localparam logic [5:0] ERR_FIRST = 6'h3a;
   localparam logic [5:0] LAST_WORD = 6'h3f;
   localparam logic [5:0] EN_FIRST = 6'h33;
   localparam logic [5:0] EN_LAST = 6'h38;
   localparam logic [11:0] PAGE_WORDS = 12'h032;
   localparam logic [11:0] TABLE_WORDS = 12'hfa0;
   localparam logic [7:0] DATA_PAGES = 8'h50;
   localparam logic [7:0] CONFIG_CODE = 8'hff;
   localparam int NUM_CMDS = 96;
   localparam int MAX_TRIES = 3;
endpackage
`default_nettype wire

// [hdl/table_memory.sv]
`default_nettype none
module table_memory #(
   parameter int DEPTH = 4000,
   parameter int WIDTH = 16,
   parameter int AW = 12
) (
   // Clock
   input wire logic clock,
   input wire logic ce,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [WIDTH-1:0] wdata,
   // Read port, one cycle latency
   input wire logic [AW-1:0] raddr,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   initial begin
      if (DEPTH > (1 << AW)) $error("table_memory: DEPTH does not fit AW");
   end

   // No reset so the array maps onto block memory
   always_ff @(posedge clock) begin
      if (ce) begin
         if (we) begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule // table_memory
`default_nettype wire

// [sim/host_model.sv]
`default_nettype none
module host_model (
   // Clock
   input wire logic clock,
   // Write transfer towards the block
   output logic wr_word_valid,
   output logic [5:0] wr_word_index,
   output logic [15:0] wr_word_data,
   output logic wr_end,
   // Read transfer from the block
   output logic rd_req,
   input wire logic rd_word_valid,
   input wire logic [5:0] rd_word_index,
   input wire logic [15:0] rd_word_data,
   input wire logic rd_end
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] rd_buf [0:63];
   logic seq_ok;
   initial begin
      wr_word_valid = 1'b0;
      wr_word_index = 6'h00;
      wr_word_data = 16'h0000;
      wr_end = 1'b0;
      rd_req = 1'b0;
      seq_ok = 1'b1;
   end
   // Word 0 first, then data and enable words in order
   task automatic write_buf(input logic [7:0] page, input logic [15:0] base, input logic [95:0] en);
      int i;
      for (i = 0; i < 57; i++) begin
         @(posedge clock);
         #2;
         wr_word_valid = 1'b1;
         wr_word_index = 6'(i);
         wr_word_data = (i == 0) ? {8'h00, page} : (i < 51) ? base + 16'(i) : en[16*(i-51) +: 16];
      end
      @(posedge clock);
      #2;
      wr_word_valid = 1'b0;
      // Idle data is inverted so a stale value never looks valid
      wr_word_data = ~wr_word_data;
      wr_end = 1'b1;
      @(posedge clock);
      #2;
      wr_end = 1'b0;
   endtask
   // Always takes the full 64 word buffer
   task automatic read_buf();
      int n;
      int k;
      @(posedge clock);
      #2;
      rd_req = 1'b1;
      @(posedge clock);
      #2;
      rd_req = 1'b0;
      n = 0;
      // Words are looked at one step after the edge that launches them
      do begin
         @(posedge clock);
         #1;
         n++;
      end while (rd_word_valid !== 1'b1 && n < 8);
      if (n != 2) seq_ok = 1'b0;
      for (k = 0; k < 64; k++) begin
         if (k > 0) begin
            @(posedge clock);
            #1;
         end
         if (rd_word_valid !== 1'b1 || rd_word_index !== 6'(k) || rd_end !== 1'(k == 63)) seq_ok = 1'b0;
         rd_buf[k] = rd_word_data;
      end
   endtask
endmodule // host_model
`default_nettype wire

// [sim/test_block_transfer_command_pager.sv]
`default_nettype none
module test_block_transfer_command_pager;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst, ce, wr_word_valid, wr_end, rd_req, rd_word_valid, rd_end, command_control_mode;
   logic [5:0] wr_word_index, rd_word_index;
   logic [15:0] wr_word_data, rd_word_data, port_wr_data;
   logic [6:0] read_page_count, cmd_number;
   logic [7:0] write_start_code, write_block_count;
   logic port_wr_valid, port_wr_ready, cmd_start, cmd_ok, cmd_fail, fail_all;
   logic [11:0] port_wr_addr;
   logic [15:0] tbl [0:99];
   logic [15:0] exp_map [0:11];
   int n_mismatch, check_count, n_starts, rd_count, cycles;
   block_transfer_command_pager uut (.clock(clock), .rst(rst), .ce(ce), .wr_word_valid(wr_word_valid),
      .wr_word_index(wr_word_index), .wr_word_data(wr_word_data), .wr_end(wr_end), .rd_req(rd_req),
      .rd_word_valid(rd_word_valid), .rd_word_index(rd_word_index), .rd_word_data(rd_word_data), .rd_end(rd_end),
      .command_control_mode(command_control_mode), .read_page_count(read_page_count),
      .write_start_code(write_start_code), .write_block_count(write_block_count), .port_wr_valid(port_wr_valid),
      .port_wr_addr(port_wr_addr), .port_wr_data(port_wr_data), .port_wr_ready(port_wr_ready),
      .cmd_start(cmd_start), .cmd_number(cmd_number), .cmd_ok(cmd_ok), .cmd_fail(cmd_fail));
   host_model host (.clock(clock), .wr_word_valid(wr_word_valid), .wr_word_index(wr_word_index),
      .wr_word_data(wr_word_data), .wr_end(wr_end), .rd_req(rd_req), .rd_word_valid(rd_word_valid),
      .rd_word_index(rd_word_index), .rd_word_data(rd_word_data), .rd_end(rd_end));
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Ceiling well above the roughly 800 cycles the sequence needs
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("mismatch at %0t: run did not finish", $time);
         results();
      end
   end
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // Command engine stand-in: answers each attempt two cycles after its start
   initial begin
      cmd_ok = 1'b0;
      cmd_fail = 1'b0;
      forever begin
         @(posedge clock);
         #2;
         cmd_ok = 1'b0;
         cmd_fail = 1'b0;
         // A retry start already stands here, right after the result edge
         if (cmd_start === 1'b1) begin
            n_starts++;
            repeat (2) @(posedge clock);
            #2;
            if (fail_all) cmd_fail = 1'b1;
            else cmd_ok = 1'b1;
         end
      end
   end
   task automatic host_write(input int page, input logic [15:0] base, input logic [95:0] en);
      int i;
      host.write_buf(8'(page), base, en);
      for (i = 1; i < 51; i++) tbl[page*50+i-1] = base + 16'(i);
   endtask
   task automatic port_write(input logic [11:0] a, input logic [15:0] d);
      int n;
      logic taken;
      @(posedge clock);
      #2;
      port_wr_valid = 1'b1;
      port_wr_addr = a;
      port_wr_data = d;
      n = 0;
      taken = 1'b0;
      // Ready is read while it stands, before the edge that takes the word
      while (!taken && n < 100) begin
         taken = (port_wr_ready === 1'b1);
         @(posedge clock);
         #2;
         n++;
      end
      if (!taken) begin
         n_mismatch++;
         $display("mismatch at %0t: serial write never taken", $time);
      end
      port_wr_valid = 1'b0;
      port_wr_addr = ~a;
      port_wr_data = ~d;
   endtask
   // Two pages and two write codes are configured, so both alternate
   task automatic do_read();
      int k;
      int page;
      page = rd_count % 2;
      host.read_buf();
      rd_count++;
      check({15'h0000, host.seq_ok}, 16'h0001, "read framing");
      check(host.rd_buf[0], 16'(page), "page id");
      check(host.rd_buf[1], 16'h0005 + 16'(page), "write code");
      for (k = 2; k < 52; k++) check(host.rd_buf[k], tbl[page*50+k-2], "data word");
      for (k = 52; k < 64; k++) check(host.rd_buf[k], exp_map[k-52], "status word");
   endtask
   task automatic wait_cmds(input int exp);
      int n;
      n = 0;
      while (n_starts < exp && n < 200) begin
         @(posedge clock);
         n++;
      end
      repeat (8) @(posedge clock);
   endtask
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      command_control_mode = 1'b1;
      read_page_count = 7'h02;
      write_start_code = 8'h05;
      write_block_count = 8'h02;
      port_wr_valid = 1'b0;
      port_wr_addr = 12'h000;
      port_wr_data = 16'h0000;
      fail_all = 1'b0;
      for (int i = 0; i < 12; i++) exp_map[i] = 16'h0000;
      repeat (2) @(posedge clock);
      #2;
      rst = 1'b0;
      host_write(0, 16'h1000, 96'h0);
      // A serial write issued inside a host write transfer waits for it and lands last
      fork
         host_write(1, 16'h2000, 96'h0);
         begin
            repeat (5) @(posedge clock);
            port_write(12'h033, 16'h5a5a);
         end
      join
      tbl[51] = 16'h5a5a;
      port_write(12'h032, 16'habcd);
      tbl[50] = 16'habcd;
      port_write(12'h063, 16'h1234);
      tbl[99] = 16'h1234;
      repeat (3) do_read();
      host_write(0, 16'h1000, 96'h1);
      wait_cmds(1);
      exp_map[0] = 16'h0001;
      check(16'(n_starts), 16'h0001, "start count");
      check({9'h000, cmd_number}, 16'h0000, "command number");
      do_read();
      host_write(0, 16'h1000, 96'h1);
      wait_cmds(1);
      check(16'(n_starts), 16'h0001, "steady enable");
      fail_all = 1'b1;
      host_write(0, 16'h1000, {64'h0, 16'h0002, 16'h0001});
      wait_cmds(4);
      exp_map[7] = 16'h0002;
      check(16'(n_starts), 16'h0004, "attempt count");
      check({9'h000, cmd_number}, 16'h0011, "failed command number");
      do_read();
      host_write(0, 16'h1000, 96'h0);
      command_control_mode = 1'b0;
      host_write(0, 16'h1000, 96'h4);
      wait_cmds(4);
      check(16'(n_starts), 16'h0004, "mode off");
      results();
   end
endmodule // test_block_transfer_command_pager
`default_nettype wire
